/* hw/alt_consts.svh */
`ifndef ALT_CONSTS_SVH
`define ALT_CONSTS_SVH

// Register byte offsets
`define ALT_OFF_CTRL      8'h00
`define ALT_OFF_LOW       8'h04
`define ALT_OFF_HIGH      8'h08
`define ALT_OFF_GAIN      8'h0c
`define ALT_OFF_STATUS    8'h10
`define ALT_OFF_MASK      8'h14
`define ALT_OFF_CMD       8'h18
`define ALT_OFF_SAMPLE    8'h1c

// Control field positions
`define ALT_CTRL_EN       0
`define ALT_CTRL_MODE_LO  1
`define ALT_CTRL_MODE_HI  3
`define ALT_CTRL_SRC_LO   4
`define ALT_CTRL_SRC_HI   6
`define ALT_CTRL_START_LO 8
`define ALT_CTRL_START_HI 9

// Status bits
`define ALT_ST_RISE       0
`define ALT_ST_FALL       1
`define ALT_ST_START      2

// Reset values
`define ALT_CTRL_RST      32'h0000_0000
`define ALT_LOW_RST       8'h00
`define ALT_HIGH_RST      8'hff
`define ALT_GAIN_RST      12'h222
`define ALT_MASK_RST      3'h0
`define ALT_STATUS_RST    3'h0

// Sizes
`define ALT_NCH           4
`define ALT_NSRC          5
`define ALT_NGAIN         8
`define ALT_NSTEPS        256
`define ALT_PIN_STEP_MV   78

`endif

/* hw/alt_pkg.sv */
package alt_pkg;
	typedef enum logic [2:0] {
		ALT_MODE_BELOW  = 3'h0,
		ALT_MODE_ABOVE  = 3'h1,
		ALT_MODE_INSIDE = 3'h2,
		ALT_MODE_HHYST  = 3'h3,
		ALT_MODE_LHYST  = 3'h4
	} alt_mode_t;

	typedef enum logic [2:0] {
		ALT_SRC_PIN = 3'h0,
		ALT_SRC_CH0 = 3'h1,
		ALT_SRC_CH1 = 3'h2,
		ALT_SRC_CH2 = 3'h3,
		ALT_SRC_CH3 = 3'h4
	} alt_src_t;

	typedef enum logic [1:0] {
		ALT_START_SW  = 2'h0,
		ALT_START_EXT = 2'h1,
		ALT_START_LVL = 2'h2
	} alt_start_t;

	typedef enum logic {
		ALT_ARMED = 1'b0,
		ALT_FIRED = 1'b1
	} alt_state_t;
endpackage : alt_pkg

/* hw/alt_sync.sv */
`timescale 1ns/1ns
module alt_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;
endmodule : alt_sync

/* hw/alt_compare.sv */
`timescale 1ns/1ns
`include "alt_consts.svh"
module alt_compare (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               enable,
	input  wire alt_pkg::alt_mode_t mode,
	input  wire logic [7:0]         sample,
	input  wire logic [7:0]         low_threshold,
	input  wire logic [7:0]         high_threshold,
	output logic                    level
);
	import alt_pkg::*;

	alt_state_t state_r;
	alt_state_t state_nxt;
	logic       level_r;
	logic       level_nxt;
	logic       below_lo;
	logic       above_hi;

	// Samples are offset binary: 8'h80 is zero volts
	assign below_lo = sample < low_threshold;
	assign above_hi = sample > high_threshold;

	always_comb begin
		state_nxt = state_r;
		level_nxt = 1'b0;
		if (enable) begin
			unique case (mode)
				ALT_MODE_BELOW:  level_nxt = below_lo;
				ALT_MODE_ABOVE:  level_nxt = above_hi;
				ALT_MODE_INSIDE: level_nxt = !below_lo && !above_hi;
				ALT_MODE_HHYST: begin
					if (state_r == ALT_ARMED && above_hi)
						state_nxt = ALT_FIRED;
					else if (state_r == ALT_FIRED && below_lo)
						state_nxt = ALT_ARMED;
					level_nxt = (state_nxt == ALT_FIRED);
				end
				ALT_MODE_LHYST: begin
					if (state_r == ALT_ARMED && below_lo)
						state_nxt = ALT_FIRED;
					else if (state_r == ALT_FIRED && above_hi)
						state_nxt = ALT_ARMED;
					level_nxt = (state_nxt == ALT_FIRED);
				end
				default: level_nxt = 1'b0;
			endcase
		end else begin
			state_nxt = ALT_ARMED;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ALT_ARMED;
			level_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;

	property p_below;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_BELOW) |=> (level == $past(below_lo));
	endproperty
	a_below: assert property (p_below) else $error("below mode mismatch");

	property p_above;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_ABOVE) |=> (level == $past(above_hi));
	endproperty
	a_above: assert property (p_above) else $error("above mode mismatch");

	property p_inside;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_INSIDE && !below_lo && !above_hi) |=> level;
	endproperty
	a_inside: assert property (p_inside) else $error("inside mode missed");

	property p_hhyst;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_HHYST && above_hi) |=> level;
	endproperty
	a_hhyst: assert property (p_hhyst) else $error("high hysteresis missed");

	property p_lhyst;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_LHYST && below_lo) |=> level;
	endproperty
	a_lhyst: assert property (p_lhyst) else $error("low hysteresis missed");

	// Level only mirrors the hysteresis state after a full cycle in that mode
	property p_rearm;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_HHYST)
			##1 (enable && mode == ALT_MODE_HHYST && level && !below_lo)
			##1 (enable && mode == ALT_MODE_HHYST) |-> level;
	endproperty
	a_rearm: assert property (p_rearm) else $error("rearmed early");

	property p_rearm_low;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && mode == ALT_MODE_LHYST)
			##1 (enable && mode == ALT_MODE_LHYST && level && !above_hi)
			##1 (enable && mode == ALT_MODE_LHYST) |-> level;
	endproperty
	a_rearm_low: assert property (p_rearm_low) else $error("low side rearmed early");
endmodule : alt_compare

/* hw/alt_trigger.sv */
`timescale 1ns/1ns
`include "alt_consts.svh"
module alt_trigger (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	input  wire logic [7:0]  pin_sample,
	input  wire logic [31:0] ch_sample,
	input  wire logic        ext_trig,
	output logic             trig_ai,
	output logic             trig_ao,
	output logic             trig_ctr,
	output logic             acq_start,
	output logic             pin_analog_en,
	output logic [11:0]      ch_gain,
	output logic             irq
);
	import alt_pkg::*;

	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [7:0]  low_r;
	logic [7:0]  low_nxt;
	logic [7:0]  high_r;
	logic [7:0]  high_nxt;
	logic [11:0] gain_r;
	logic [11:0] gain_nxt;
	logic [2:0]  status_r;
	logic [2:0]  status_nxt;
	logic [2:0]  mask_r;
	logic [2:0]  mask_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        start_r;
	logic        start_nxt;
	logic        lvl_q_r;
	logic        pin_en_r;
	logic        pin_en_nxt;
	logic [7:0]  sample_sel;
	logic [7:0]  src_s [`ALT_NSRC];
	logic [7:0]  pin_s;
	logic [31:0] ch_s;
	logic        ext_s;
	logic        ext_q_r;
	logic        level;
	logic        sw_start;
	logic        enable;
	alt_mode_t   mode;
	alt_src_t    src;
	alt_start_t  start_sel;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	alt_sync #(.W(8)) u_pin_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        (pin_sample),
		.q        (pin_s)
	);

	alt_sync #(.W(33)) u_ch_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        ({ext_trig, ch_sample}),
		.q        ({ext_s, ch_s})
	);

	assign enable    = ctrl_r[`ALT_CTRL_EN];
	assign mode      = alt_mode_t'(ctrl_r[`ALT_CTRL_MODE_HI:`ALT_CTRL_MODE_LO]);
	assign src       = alt_src_t'(ctrl_r[`ALT_CTRL_SRC_HI:`ALT_CTRL_SRC_LO]);
	assign start_sel = alt_start_t'(ctrl_r[`ALT_CTRL_START_HI:`ALT_CTRL_START_LO]);

	// Pin codes are 78 mV steps across +-10 V; channel codes are full scale / 256
	assign src_s[0] = pin_s;
	genvar g;
	generate
		for (g = 0; g < `ALT_NCH; g++) begin : g_src
			assign src_s[g+1] = ch_s[8*g +: 8];
		end
	endgenerate

	always_comb begin
		sample_sel = src_s[0];
		for (int i = 1; i < `ALT_NSRC; i++) begin
			if (int'(src) == i)
				sample_sel = src_s[i];
		end
	end

	alt_compare u_cmp (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.enable         (enable),
		.mode           (mode),
		.sample         (sample_sel),
		.low_threshold  (low_r),
		.high_threshold (high_r),
		.level          (level)
	);

	assign sw_start = wr && hit(addr, `ALT_OFF_CMD) && wdata[0];

	always_comb begin
		ctrl_nxt   = ctrl_r;
		low_nxt    = low_r;
		high_nxt   = high_r;
		gain_nxt   = gain_r;
		mask_nxt   = mask_r;
		status_nxt = status_r;
		rdata_nxt  = 32'h0000_0000;
		if (wr) begin
			if (hit(addr, `ALT_OFF_CTRL))
				ctrl_nxt = {22'h0, wdata[9:8], 1'b0, wdata[6:0]};
			if (hit(addr, `ALT_OFF_LOW))
				low_nxt = wdata[7:0];
			if (hit(addr, `ALT_OFF_HIGH))
				high_nxt = wdata[7:0];
			if (hit(addr, `ALT_OFF_GAIN))
				gain_nxt = wdata[11:0];
			if (hit(addr, `ALT_OFF_MASK))
				mask_nxt = wdata[2:0];
			if (hit(addr, `ALT_OFF_STATUS))
				status_nxt = status_r & ~wdata[2:0];
		end
		// Events set after the clear so a same-cycle event wins
		if (level && !lvl_q_r)
			status_nxt[`ALT_ST_RISE] = 1'b1;
		if (!level && lvl_q_r)
			status_nxt[`ALT_ST_FALL] = 1'b1;
		if (start_nxt)
			status_nxt[`ALT_ST_START] = 1'b1;
		if (rd) begin
			unique case (addr)
				`ALT_OFF_CTRL:   rdata_nxt = ctrl_r;
				`ALT_OFF_LOW:    rdata_nxt = {24'h0, low_r};
				`ALT_OFF_HIGH:   rdata_nxt = {24'h0, high_r};
				`ALT_OFF_GAIN:   rdata_nxt = {20'h0, gain_r};
				`ALT_OFF_STATUS: rdata_nxt = {29'h0, status_r};
				`ALT_OFF_MASK:   rdata_nxt = {29'h0, mask_r};
				`ALT_OFF_SAMPLE: rdata_nxt = {23'h0, level, sample_sel};
				default:         rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		unique case (start_sel)
			ALT_START_SW:  start_nxt = sw_start;
			ALT_START_EXT: start_nxt = ext_s && !ext_q_r;
			ALT_START_LVL: start_nxt = level && !lvl_q_r;
			default:       start_nxt = 1'b0;
		endcase
		pin_en_nxt = enable && (src == ALT_SRC_PIN);
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= `ALT_CTRL_RST;
			low_r    <= `ALT_LOW_RST;
			high_r   <= `ALT_HIGH_RST;
			gain_r   <= `ALT_GAIN_RST;
			mask_r   <= `ALT_MASK_RST;
			status_r <= `ALT_STATUS_RST;
			rdata_r  <= 32'h0000_0000;
			irq_r    <= 1'b0;
			start_r  <= 1'b0;
			lvl_q_r  <= 1'b0;
			ext_q_r  <= 1'b0;
			pin_en_r <= 1'b0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			low_r    <= low_nxt;
			high_r   <= high_nxt;
			gain_r   <= gain_nxt;
			mask_r   <= mask_nxt;
			status_r <= status_nxt;
			rdata_r  <= rdata_nxt;
			irq_r    <= irq_nxt;
			start_r  <= start_nxt;
			lvl_q_r  <= level;
			ext_q_r  <= ext_s;
			pin_en_r <= pin_en_nxt;
		end
	end

	// Same registered level to every timing section
	assign trig_ai       = lvl_q_r;
	assign trig_ao       = lvl_q_r;
	assign trig_ctr      = lvl_q_r;
	assign acq_start     = start_r;
	assign pin_analog_en = pin_en_r;
	assign ch_gain       = gain_r;
	assign rdata         = rdata_r;
	assign irq           = irq_r;

	property p_trig_follow;
		@(posedge core_clk) disable iff (!rst_n)
		level |=> (trig_ai && trig_ao && trig_ctr);
	endproperty
	a_trig_follow: assert property (p_trig_follow) else $error("trigger not forwarded");

	// Back-to-back commands legally stretch the pulse, so only a lone one is checked
	property p_sw_start;
		@(posedge core_clk) disable iff (!rst_n)
		(sw_start && start_sel == ALT_START_SW)
			##1 (!sw_start && start_sel == ALT_START_SW)
			|-> acq_start ##1 !acq_start;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start lost");

	property p_pin_analog;
		@(posedge core_clk) disable iff (!rst_n)
		(enable && src == ALT_SRC_PIN) |=> pin_analog_en;
	endproperty
	a_pin_analog: assert property (p_pin_analog) else $error("pin not analog");

	property p_gain;
		@(posedge core_clk) disable iff (!rst_n)
		(wr && addr == `ALT_OFF_GAIN) |=> (ch_gain == $past(wdata[11:0]));
	endproperty
	a_gain: assert property (p_gain) else $error("gain not stored");

	property p_src;
		@(posedge core_clk) disable iff (!rst_n)
		(src == ALT_SRC_CH1) |-> (sample_sel == ch_s[15:8]);
	endproperty
	a_src: assert property (p_src) else $error("source select wrong");

	property p_src_pin;
		@(posedge core_clk) disable iff (!rst_n)
		(src == ALT_SRC_PIN) |-> (sample_sel == pin_s);
	endproperty
	a_src_pin: assert property (p_src_pin) else $error("pin source not selected");

	property p_low_store;
		@(posedge core_clk) disable iff (!rst_n)
		(wr && addr == `ALT_OFF_LOW) |=> (low_r == $past(wdata[7:0]));
	endproperty
	a_low_store: assert property (p_low_store) else $error("low threshold not stored");

	property p_high_store;
		@(posedge core_clk) disable iff (!rst_n)
		(wr && addr == `ALT_OFF_HIGH) |=> (high_r == $past(wdata[7:0]));
	endproperty
	a_high_store: assert property (p_high_store) else $error("high threshold not stored");

	property p_rdata_idle;
		@(posedge core_clk) disable iff (!rst_n)
		!rd |=> (rdata == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_mode_illegal;
		@(posedge core_clk) disable iff (!rst_n)
		(ctrl_r[`ALT_CTRL_MODE_HI:`ALT_CTRL_MODE_LO] > 3'h4) |=> !level;
	endproperty
	a_mode_illegal: assert property (p_mode_illegal) else $error("illegal mode fired");

	property p_disable;
		@(posedge core_clk) disable iff (!rst_n)
		!enable |=> !level;
	endproperty
	a_disable: assert property (p_disable) else $error("disabled unit fired");

	property p_pin_off;
		@(posedge core_clk) disable iff (!rst_n)
		!(enable && src == ALT_SRC_PIN) |=> !pin_analog_en;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin analog while unused");

	property p_ext_start;
		@(posedge core_clk) disable iff (!rst_n)
		(start_sel == ALT_START_EXT && ext_s && !ext_q_r) |=> acq_start;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("external start lost");

	property p_start_once;
		@(posedge core_clk) disable iff (!rst_n)
		(acq_start && start_sel == ALT_START_EXT) |=> !acq_start;
	endproperty
	a_start_once: assert property (p_start_once) else $error("external start too long");

	property p_rise_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(level && !lvl_q_r) |=> status_r[`ALT_ST_RISE];
	endproperty
	a_rise_flag: assert property (p_rise_flag) else $error("rise flag lost");

	property p_fall_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(!level && lvl_q_r) |=> status_r[`ALT_ST_FALL];
	endproperty
	a_fall_flag: assert property (p_fall_flag) else $error("fall flag lost");

	property p_irq;
		@(posedge core_clk) disable iff (!rst_n)
		irq == |(status_r & mask_r);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_trig_low;
		@(posedge core_clk) disable iff (!rst_n)
		!level |=> (!trig_ai && !trig_ao && !trig_ctr);
	endproperty
	a_trig_low: assert property (p_trig_low) else $error("trigger stuck high");
endmodule : alt_trigger

/* dv/alt_far_model.sv */
`timescale 1ns/1ns
module alt_far_model #(
	parameter int SCANS = 3
) (
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	input  wire logic   trig_ai,
	input  wire logic   trig_ao,
	output logic [15:0] ao_updates,
	output logic [15:0] ai_scans
);
	logic       ao_q_r;
	logic       ai_q_r;
	logic [3:0] scans_left_r;
	// AI takes a scan burst per rise, AO updates on every crossing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ao_q_r       <= 1'b0;
			ai_q_r       <= 1'b0;
			scans_left_r <= 4'h0;
			ao_updates   <= 16'h0;
			ai_scans     <= 16'h0;
		end else begin
			ao_q_r <= trig_ao;
			ai_q_r <= trig_ai;
			if (trig_ao != ao_q_r) ao_updates <= ao_updates + 16'h1;
			if (trig_ai && !ai_q_r) scans_left_r <= 4'(SCANS);
			else if (scans_left_r != 4'h0) begin
				scans_left_r <= scans_left_r - 4'h1;
				ai_scans     <= ai_scans + 16'h1;
			end
		end
	end
endmodule : alt_far_model

/* dv/analog_level_trigger_tb.sv */
`timescale 1ns/1ns
`include "alt_consts.svh"
module analog_level_trigger_tb;
	import alt_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  pin_sample = 8'h00;
	logic [31:0] ch_sample = 32'h0;
	logic        ext_trig = 1'b0;
	logic        trig_ai;
	logic        trig_ao;
	logic        trig_ctr;
	logic        acq_start;
	logic        pin_analog_en;
	logic [11:0] ch_gain;
	logic        irq;
	logic [15:0] ao_updates;
	logic [15:0] ai_scans;
	logic [31:0] r;
	int          bad_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          lo, hi, m, s, lvl, fired, tog, rises, n, g;
	logic [7:0]  x;

	alt_trigger u_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin_sample(pin_sample), .ch_sample(ch_sample),
		.ext_trig(ext_trig), .trig_ai(trig_ai), .trig_ao(trig_ao), .trig_ctr(trig_ctr),
		.acq_start(acq_start), .pin_analog_en(pin_analog_en), .ch_gain(ch_gain), .irq(irq));
	alt_far_model #(.SCANS(3)) u_far (.core_clk(core_clk), .rst_n(rst_n), .trig_ai(trig_ai),
		.trig_ao(trig_ao), .ao_updates(ao_updates), .ai_scans(ai_scans));

	always #5 core_clk = ~core_clk;

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic chk_trig();
		chk({29'h0, trig_ai, trig_ao, trig_ctr}, (lvl != 0) ? 32'h7 : 32'h0, "trigger");
	endtask : chk_trig

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wrr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 r = rdata;
		chk(r, exp, "read");
		@(posedge core_clk);
		#1 chk(rdata, 32'h0, "read idle");
	endtask : rdchk

	// Model level with edge and toggle bookkeeping for the far side
	task automatic set_lvl(input int nl);
		if (nl != 0 && lvl == 0) rises++;
		if (nl != lvl) tog++;
		lvl = nl;
	endtask : set_lvl

	task automatic step(input logic [7:0] v);
		case (m)
			0: set_lvl(v < lo);
			1: set_lvl(v > hi);
			2: set_lvl(v >= lo && v <= hi);
			3: begin
				if (v > hi) fired = 1;
				else if (v < lo) fired = 0;
				set_lvl(fired);
			end
			default: begin
				if (v < lo) fired = 1;
				else if (v > hi) fired = 0;
				set_lvl(fired);
			end
		endcase
	endtask : step

	// Selected source gets the value, every other source its inverse
	task automatic drive(input int src, input logic [7:0] v);
		logic [31:0] c;
		c = {4{~v}};
		if (src != 0) c[8*(src-1) +: 8] = v;
		@(posedge core_clk);
		pin_sample <= (src == 0) ? v : ~v;
		ch_sample <= c;
		repeat (6) @(posedge core_clk);
		#1;
	endtask : drive

	initial begin
		void'($urandom(29));
		lvl = 0;
		tog = 0;
		rises = 0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		rdchk(`ALT_OFF_CTRL, 32'h0);
		rdchk(`ALT_OFF_LOW, 32'h0);
		rdchk(`ALT_OFF_HIGH, 32'hff);
		rdchk(`ALT_OFF_GAIN, 32'h222);
		rdchk(`ALT_OFF_MASK, 32'h0);
		rdchk(`ALT_OFF_STATUS, 32'h0);
		rdchk(8'h20, 32'h0);
		chk({20'h0, ch_gain}, 32'h222, "gain out");
		$display("test reset done");
		for (int k = 0; k < 10; k++) begin
			m = k % 5;
			s = (k + k / 5) % 5;
			lo = $urandom_range(32, 112);
			hi = lo + $urandom_range(16, 96);
			wrr(`ALT_OFF_CTRL, 32'h0);
			fired = 0;
			set_lvl(0);
			wrr(`ALT_OFF_LOW, 32'(lo));
			wrr(`ALT_OFF_HIGH, 32'(hi));
			for (int j = 0; j < 13; j++) begin
				x = (j == 1) ? 8'(lo - 1) : (j == 2) ? 8'(hi) : (j == 3) ? 8'(hi + 1) : 8'(lo);
				if (j > 3) x = 8'($urandom_range(0, 255));
				drive(s, x);
				if (j == 0) begin
					wrr(`ALT_OFF_CTRL, 32'(s * 16 + m * 2 + 1));
					repeat (6) @(posedge core_clk);
					#1 chk({31'h0, pin_analog_en}, 32'(s == 0), "analog pin");
				end
				step(x);
				chk_trig();
			end
			$display("test mode %0d src %0d done", m, s);
		end
		wrr(`ALT_OFF_CTRL, 32'h0);
		set_lvl(0);
		wrr(`ALT_OFF_LOW, 32'h40);
		drive(0, 8'h50);
		wrr(`ALT_OFF_STATUS, 32'h7);
		wrr(`ALT_OFF_MASK, 32'h1);
		wrr(`ALT_OFF_CTRL, 32'h1);
		drive(0, 8'h30);
		set_lvl(1);
		rdchk(`ALT_OFF_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h1, "irq set");
		wrr(`ALT_OFF_STATUS, 32'h1);
		repeat (2) @(posedge core_clk);
		#1 chk({31'h0, irq}, 32'h0, "irq clear");
		drive(0, 8'h50);
		set_lvl(0);
		rdchk(`ALT_OFF_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0, "irq masked");
		$display("test status done");
		wrr(`ALT_OFF_STATUS, 32'h7);
		wrr(`ALT_OFF_MASK, 32'h4);
		wrr(`ALT_OFF_CMD, 32'h1);
		#1 chk({31'h0, acq_start}, 32'h1, "sw start");
		@(posedge core_clk);
		#1 chk({31'h0, acq_start}, 32'h0, "sw pulse");
		@(posedge core_clk);
		#1 chk({31'h0, irq}, 32'h1, "start irq");
		wrr(`ALT_OFF_CTRL, 32'h101);
		ext_trig <= 1'b1;
		n = 0;
		repeat (10) begin
			@(posedge core_clk);
			#1 n += int'(acq_start);
		end
		chk(32'(n), 32'h1, "ext start");
		@(posedge core_clk);
		ext_trig <= 1'b0;
		// Start on the trigger's own rise, then an illegal mode code
		wrr(`ALT_OFF_STATUS, 32'h7);
		wrr(`ALT_OFF_CTRL, 32'h201);
		drive(0, 8'h30);
		set_lvl(1);
		chk_trig();
		rdchk(`ALT_OFF_STATUS, 32'h5);
		rdchk(`ALT_OFF_SAMPLE, 32'h130);
		rdchk(`ALT_OFF_CMD, 32'h0);
		wrr(`ALT_OFF_CTRL, 32'h20b);
		set_lvl(0);
		repeat (6) @(posedge core_clk);
		#1 chk_trig();
		g = $urandom_range(0, 4095);
		wrr(`ALT_OFF_GAIN, 32'(g));
		rdchk(`ALT_OFF_GAIN, 32'(g));
		chk({20'h0, ch_gain}, 32'(g), "gain out");
		$display("test start and gain done");
		repeat (10) @(posedge core_clk);
		chk({16'h0, ao_updates}, 32'(tog), "updates");
		chk({16'h0, ai_scans}, 32'(rises * 3), "scans");
		$display("test consumers done");
		summarize();
	end
endmodule : analog_level_trigger_tb
